/* term_timing_regs.svh */
// Constants for the termination and leveling timing block.
// Assumes inclusion from the package and the design file only.
// Notes on behaviour
// - Termination on after write plus additive minus two
// - Termination off after the same latency
// - Turn-off completes 0.3 to 0.7 cycle later
// - Power-down DLL off: async switch 2 to 8.5ns; block switches on the fifth mclk edge, 40 to 50ns
// - Chopped write: nominal after four plus off-latency
// - Full write: nominal after six plus off-latency
// - Leveling feedback within 9ns (7.5ns fastest grade); block raises it on the third mclk edge, 20 to 30ns
// - Cycle delays count real link clock edges
`ifndef TERM_TIMING_REGS_SVH
`define TERM_TIMING_REGS_SVH
// ----------------------------------------
// Latency and timing figures
// ----------------------------------------
`define LAT_OFFSET        5'h02
`define SKEW_CHOP_CK      5'h04
`define SKEW_FULL_CK      5'h06
`define LEVEL_WAIT_CK     6'h28
`define MCLK_PERIOD_PS    10000
`define ASYNC_MIN_PS      2000
`define ASYNC_MAX_PS      8500
`define FEEDBACK_MAX_PS   9000
`define ASYNC_MIN_CYC     ((`ASYNC_MIN_PS + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define FEEDBACK_MAX_CYC  (`FEEDBACK_MAX_PS / `MCLK_PERIOD_PS)
`define DELAY_LINE_LEN    32
`define RTT_RESET         3'h0
`endif

/* term_timing_pkg.sv */
// Types for the termination and leveling timing block.
// Assumes the constant header sits in the same folder.
package term_timing_pkg;
	`include "term_timing_regs.svh"
	// Termination selection seen at the pads
	typedef enum logic [1:0]
	{
		RTT_OFF = 2'b00,
		NOMINAL_TERMINATION = 2'b01,
		RTT_WRV = 2'b10
	} rtt_sel_t;
	// Link side command sample
	typedef struct packed
	{
		logic term_ctl;
		logic write_cmd;
		logic chop;
	} link_cmd_t;
	// Mode settings programmed by the controller
	typedef struct packed
	{
		logic [3:0] write_latency_setting;
		logic [3:0] additive_latency_setting;
		logic [2:0] nominal_termination;
		logic [2:0] write_termination;
		logic       dynamic_en;
		logic       dll_off_pd;
		logic       leveling;
	} mode_cfg_t;
endpackage : term_timing_pkg

/* term_timing.sv */
// Termination latency, dynamic termination and leveling feedback.
// Assumes link_clk is the device input clock; mode settings are
// static while link traffic runs; mclk is the device core clock.
`timescale 1ns/1ps
`include "term_timing_regs.svh"
module term_timing
	import term_timing_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      sys_rst,
	input  wire logic      link_clk,
	input  wire logic      link_rst,
	input  wire link_cmd_t link_cmd,
	input  wire mode_cfg_t mode_cfg,
	input  wire logic      strobe,
	output logic [2:0]     rtt_value,
	output rtt_sel_t       rtt_sel,
	output logic           rtt_settling,
	output logic           level_fb,
	output logic           level_fb_oe_n
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Synchronous latency shared by on and off paths
	function automatic logic [4:0] term_latency(input mode_cfg_t c);
		logic [4:0] s;
		s = {1'b0, c.write_latency_setting}
			+ {1'b0, c.additive_latency_setting};
		term_latency = (s > `LAT_OFFSET) ? s - `LAT_OFFSET : 5'h00;
	endfunction : term_latency

	// Tap of a history line at the latency; zero latency bypasses
	function automatic logic line_tap(
		input logic [`DELAY_LINE_LEN-1:0] line,
		input logic                       now,
		input logic [4:0]                 l);
		if (l == 5'h00)
			line_tap = now;
		else
			line_tap = line[l - 5'h01];
	endfunction : line_tap

	// ----------------------------------------
	// Link domain: latency pipelines
	// ----------------------------------------
	logic [`DELAY_LINE_LEN-1:0] ctl_line_q, ctl_line_d;
	logic [4:0]                 lat;
	logic                       term_on_q, term_on_d;
	logic [3:0]                 wr_cnt_q, wr_cnt_d;
	logic                       wr_act_q, wr_act_d;
	logic                       half_q, half_d;

	assign lat = term_latency(mode_cfg);

	// Shift control history and count the write window; tap at the latency
	always_comb
	begin
		ctl_line_d = {ctl_line_q[`DELAY_LINE_LEN-2:0], link_cmd.term_ctl};
		// Latency tap drives both on and off edges
		term_on_d = line_tap(ctl_line_q, link_cmd.term_ctl, lat);
		wr_cnt_d = wr_cnt_q;
		wr_act_d = wr_act_q;
		if (link_cmd.write_cmd && mode_cfg.dynamic_en)
		begin
			wr_act_d = 1'b1;
			// Window holds through count zero, so load one less
			wr_cnt_d = link_cmd.chop ? 4'(`SKEW_CHOP_CK) - 4'h1
				: 4'(`SKEW_FULL_CK) - 4'h1;
		end
		else if (wr_cnt_q != 4'h0)
			wr_cnt_d = wr_cnt_q - 4'h1;
		else
			wr_act_d = 1'b0;
		half_d = term_on_q & ~term_on_d;
	end

	// Write window shifted by off-latency, tracked as its own line
	logic [`DELAY_LINE_LEN-1:0] wr_line_q, wr_line_d;
	logic                       wr_late;
	always_comb
	begin
		wr_line_d = {wr_line_q[`DELAY_LINE_LEN-2:0], wr_act_q};
		wr_late = line_tap(wr_line_q, wr_act_q, lat);
	end

	always_ff @(posedge link_clk)
	begin
		if (link_rst)
		begin
			ctl_line_q   <= '0;
			term_on_q    <= 1'b0;
			wr_cnt_q     <= 4'h0;
			wr_act_q     <= 1'b0;
			half_q       <= 1'b0;
			wr_line_q    <= '0;
		end
		else
		begin
			ctl_line_q   <= ctl_line_d;
			term_on_q    <= term_on_d;
			wr_cnt_q     <= wr_cnt_d;
			wr_act_q     <= wr_act_d;
			half_q       <= half_d;
			wr_line_q    <= wr_line_d;
		end
	end

	// Turn-off lands on the falling edge: half a cycle into window
	logic settle_q;
	always_ff @(negedge link_clk)
	begin
		if (link_rst)
			settle_q <= 1'b0;
		else
			settle_q <= half_q;
	end

	// ----------------------------------------
	// Crossing into mclk
	// ----------------------------------------
	// Two flops per level; first stage read by second only
	logic [2:0] sync1_q, sync2_q;
	logic [1:0] pin_s1_q, pin_s2_q;
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sync1_q  <= 3'h0;
			sync2_q  <= 3'h0;
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
		end
		else
		begin
			sync1_q  <= {term_on_q, wr_late, settle_q};
			sync2_q  <= sync1_q;
			pin_s1_q <= {link_cmd.term_ctl, strobe};
			pin_s2_q <= pin_s1_q;
		end
	end

	// ----------------------------------------
	// Core domain: termination select and leveling feedback
	// ----------------------------------------
	logic [2:0] rtt_value_q, rtt_value_d;
	rtt_sel_t   rtt_sel_q, rtt_sel_d;
	logic       settling_q, settling_d;
	logic       fb_q, fb_d;
	logic       fb_oe_n_q, fb_oe_n_d;
	logic       strobe_prev_q;
	logic [3:0] async_cnt_q, async_cnt_d;
	logic       async_tgt_q, async_tgt_d;
	logic       async_on_q, async_on_d;
	logic       want_on;

	always_comb
	begin
		// Asynchronous path ignores latency in DLL-off power-down
		async_tgt_d = pin_s2_q[1];
		async_cnt_d = async_cnt_q;
		async_on_d  = async_on_q;
		if (pin_s2_q[1] != async_tgt_q)
			async_cnt_d = 4'h0;
		else if (async_on_q != async_tgt_q)
		begin
			if (async_cnt_q + 4'h1 >= 4'(`ASYNC_MIN_CYC))
				async_on_d = async_tgt_q;
			else
				async_cnt_d = async_cnt_q + 4'h1;
		end
		want_on = mode_cfg.dll_off_pd ? async_on_q : sync2_q[2];
		rtt_sel_d   = RTT_OFF;
		rtt_value_d = `RTT_RESET;
		if (want_on && sync2_q[1] && mode_cfg.dynamic_en)
		begin
			rtt_sel_d   = RTT_WRV;
			rtt_value_d = mode_cfg.write_termination;
		end
		else if (want_on)
		begin
			rtt_sel_d   = NOMINAL_TERMINATION;
			rtt_value_d = mode_cfg.nominal_termination;
		end
		settling_d = sync2_q[0];
		// Feedback: strobe rising edge sets the feedback high until leveling ends
		fb_d      = fb_q;
		fb_oe_n_d = ~mode_cfg.leveling;
		if (mode_cfg.leveling && pin_s2_q[0] && !strobe_prev_q)
			fb_d = 1'b1;
		else if (!mode_cfg.leveling)
			fb_d = 1'b0;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rtt_value_q   <= `RTT_RESET;
			rtt_sel_q     <= RTT_OFF;
			settling_q    <= 1'b0;
			fb_q          <= 1'b0;
			fb_oe_n_q     <= 1'b1;
			strobe_prev_q <= 1'b0;
			async_cnt_q   <= 4'h0;
			async_tgt_q   <= 1'b0;
			async_on_q    <= 1'b0;
		end
		else
		begin
			rtt_value_q   <= rtt_value_d;
			rtt_sel_q     <= rtt_sel_d;
			settling_q    <= settling_d;
			fb_q          <= fb_d;
			fb_oe_n_q     <= fb_oe_n_d;
			strobe_prev_q <= pin_s2_q[0];
			async_cnt_q   <= async_cnt_d;
			async_tgt_q   <= async_tgt_d;
			async_on_q    <= async_on_d;
		end
	end

	assign rtt_value     = rtt_value_q;
	assign rtt_sel       = rtt_sel_q;
	assign rtt_settling  = settling_q;
	assign level_fb      = fb_q;
	assign level_fb_oe_n = fb_oe_n_q;
endmodule : term_timing

/* term_timing_sva.sv */
// Output checker for term_timing, core clock domain.
// Assumes the bind below; mode settings change only when idle.
`timescale 1ns/1ps
module term_timing_sva
	import term_timing_pkg::*;
(
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire mode_cfg_t  mode_cfg,
	input wire logic       strobe,
	input wire logic [2:0] rtt_value,
	input wire rtt_sel_t   rtt_sel,
	input wire logic       rtt_settling,
	input wire logic       level_fb,
	input wire logic       level_fb_oe_n
);
	// All checks ride the core clock
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	a_rst_all_off: assert property ($past(sys_rst) |->
		rtt_sel == RTT_OFF && level_fb_oe_n) else $error("not idle");
	a_nom_value: assert property (rtt_sel == NOMINAL_TERMINATION |->
		rtt_value == mode_cfg.nominal_termination) else $error("bad nom");
	a_wr_value: assert property (rtt_sel == RTT_WRV |->
		rtt_value == mode_cfg.write_termination) else $error("bad wr");
	a_no_dynamic: assert property (!mode_cfg.dynamic_en |->
		rtt_sel != RTT_WRV) else $error("write value unasked");
	a_fb_released: assert property ((!mode_cfg.leveling)[*2] |->
		level_fb_oe_n && !level_fb) else $error("fb driven");
	a_fb_driven: assert property ((mode_cfg.leveling)[*2] |->
		!level_fb_oe_n) else $error("fb not driven");
	a_fb_answer: assert property (mode_cfg.leveling && $rose(strobe)
		|-> ##[1:5] level_fb) else $error("fb late");
	// Settle window must accompany a synchronous turn-off
	a_off_settle: assert property (!mode_cfg.dll_off_pd &&
		$past(rtt_sel) != RTT_OFF && rtt_sel == RTT_OFF |->
		##[1:4] rtt_settling) else $error("no settle window");
	c_write: cover property (rtt_sel == RTT_WRV);
	c_fb: cover property ($rose(level_fb));
	c_settle: cover property ($rose(rtt_settling));
endmodule : term_timing_sva
bind term_timing term_timing_sva i_term_timing_sva (.mclk(mclk),
	.sys_rst(sys_rst), .mode_cfg(mode_cfg), .strobe(strobe),
	.rtt_value(rtt_value), .rtt_sel(rtt_sel), .rtt_settling(rtt_settling),
	.level_fb(level_fb), .level_fb_oe_n(level_fb_oe_n));

/* mem_ctrl.sv */
// Controller model: termination control, writes and strobe.
// Assumes a free running link clock from the bench.
`timescale 1ns/1ps
module mem_ctrl
	import term_timing_pkg::*;
(
	input  wire logic link_clk,
	output link_cmd_t link_cmd,
	output logic      strobe
);
	realtime t_take;
	// Idle lines until a task runs
	initial
	begin
		link_cmd = '0;
		strobe = 1'b0;
	end
	// Control high for n sampled edges; write on the first
	task automatic term_burst(input int n, input logic wr, input logic ch);
		@(negedge link_clk) link_cmd = '{1'b1, wr, ch};
		@(posedge link_clk) t_take = $realtime;
		@(negedge link_clk) link_cmd.write_cmd = 1'b0;
		repeat (n - 1) @(negedge link_clk);
		link_cmd = '0;
	endtask : term_burst
	// Leveling entry wait counted in real edges, then one strobe
	task automatic level_strobe();
		repeat (40) @(negedge link_clk);
		strobe = 1'b1;
		repeat (2) @(negedge link_clk);
		strobe = 1'b0;
	endtask : level_strobe
endmodule : mem_ctrl

/* tb_term_timing.sv */
// Self-checking bench for term_timing with a controller model.
// Assumes mem_ctrl and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin \
	n_errors++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); \
	end end
module tb_term_timing
	import term_timing_pkg::*;
;
	logic       mclk = 1'b0;
	logic       link_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       link_rst = 1'b1;
	logic       strobe;
	link_cmd_t  link_cmd;
	mode_cfg_t  mode_cfg = '{4'h5, 4'h0, 3'h3, 3'h5, 1'b0, 1'b0, 1'b0};
	logic [2:0] rtt_value;
	rtt_sel_t   rtt_sel;
	logic       rtt_settling, level_fb, level_fb_oe_n;
	int         n_errors = 0, comparisons = 0, cyc = 0;
	term_timing i_term_timing (.mclk(mclk), .sys_rst(sys_rst),
		.link_clk(link_clk), .link_rst(link_rst), .link_cmd(link_cmd),
		.mode_cfg(mode_cfg), .strobe(strobe), .rtt_value(rtt_value),
		.rtt_sel(rtt_sel), .rtt_settling(rtt_settling),
		.level_fb(level_fb), .level_fb_oe_n(level_fb_oe_n));
	mem_ctrl i_mem_ctrl (.link_clk(link_clk), .link_cmd(link_cmd),
		.strobe(strobe));
	// Clocks; link phase offset keeps the domains unrelated
	initial forever #5 mclk = ~mclk;
	initial
	begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	task automatic results();
		$display("checks %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	// Hang guard on core cycles
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			results();
		end
	end
	// Bounded wait; sampled mid-cycle to avoid edge races
	task automatic wait_sel(input rtt_sel_t s, output realtime t);
		for (int k = 0; k < 200 && rtt_sel !== s; k++)
			@(negedge mclk);
		t = $realtime;
	endtask : wait_sel
	// Sync path plus link latency; slack covers the crossing
	function automatic logic win(realtime d, realtime b);
		return d >= b + 15 && d <= b + 40;
	endfunction : win
	task automatic t_latency();
		realtime t;
		logic    st;
		for (int w = 5; w <= 8; w += 3)
		begin
			@(negedge mclk) mode_cfg.write_latency_setting = w[3:0];
			fork
				i_mem_ctrl.term_burst(4, 1'b0, 1'b0);
				wait_sel(NOMINAL_TERMINATION, t);
			join
			`CHK("on_lat", 1'b1, win(t - i_mem_ctrl.t_take, (w - 2) * 15))
			`CHK("nom_val", 3'h3, rtt_value)
			wait_sel(RTT_OFF, t);
			`CHK("off_lat", 1'b1, win(t - i_mem_ctrl.t_take, (w + 2) * 15))
			st = 1'b0;
			repeat (6) @(negedge mclk) st |= (rtt_settling === 1'b1);
			`CHK("settle", 1'b1, st)
		end
	endtask : t_latency
	task automatic t_dynamic();
		realtime t1, t2;
		@(negedge mclk) mode_cfg.dynamic_en = 1'b1;
		for (int c = 0; c < 2; c++)
		begin
			fork
				i_mem_ctrl.term_burst(10, 1'b1, c[0]);
				begin
					wait_sel(RTT_WRV, t1);
					`CHK("wr_val", 3'h5, rtt_value)
					wait_sel(NOMINAL_TERMINATION, t2);
				end
			join
			t2 = t2 - t1 - (6 - 2 * c) * 15;
			`CHK("wr_span", 1'b1, t2 > -12 && t2 < 12)
			wait_sel(RTT_OFF, t1);
		end
	endtask : t_dynamic
	task automatic t_refused();
		logic    seen;
		realtime t;
		seen = 1'b0;
		@(negedge mclk) mode_cfg.dynamic_en = 1'b0;
		fork
			i_mem_ctrl.term_burst(10, 1'b1, 1'b0);
			repeat (40) @(negedge mclk) seen |= (rtt_sel === RTT_WRV);
		join
		`CHK("wr_refused", 1'b0, seen)
		wait_sel(RTT_OFF, t);
	endtask : t_refused
	task automatic t_async();
		realtime t;
		@(negedge mclk) mode_cfg.dll_off_pd = 1'b1;
		fork
			i_mem_ctrl.term_burst(4, 1'b0, 1'b0);
			wait_sel(NOMINAL_TERMINATION, t);
		join
		`CHK("async_on", 1'b1, t - i_mem_ctrl.t_take < 60)
		wait_sel(RTT_OFF, t);
		// Let the synchronous path drain before leaving power-down
		repeat (20) @(negedge mclk);
		@(negedge mclk) mode_cfg.dll_off_pd = 1'b0;
	endtask : t_async
	task automatic t_level();
		@(negedge mclk) mode_cfg.leveling = 1'b1;
		fork
			i_mem_ctrl.level_strobe();
			begin
				wait (strobe === 1'b1);
				repeat (5) @(negedge mclk);
				`CHK("level_fb", 1'b1, level_fb)
				`CHK("fb_oe_n", 1'b0, level_fb_oe_n)
			end
		join
		@(negedge mclk) mode_cfg.leveling = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("fb_release", 1'b1, level_fb_oe_n)
		`CHK("fb_clear", 1'b0, level_fb)
	endtask : t_level
	// Main sequence after a five cycle reset
	initial
	begin
		repeat (5) @(negedge mclk);
		sys_rst = 1'b0;
		link_rst = 1'b0;
		@(negedge mclk);
		`CHK("idle_sel", RTT_OFF, rtt_sel)
		t_latency();
		t_dynamic();
		t_refused();
		t_async();
		t_level();
		results();
	end
endmodule : tb_term_timing
